// >>> hdl/sfdc_defines.svh
// register offsets, field positions, reset values and timing counts
`ifndef SFDC_DEFINES_SVH
`define SFDC_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SFDC_ADDR_BP1_SEL   8'ha4
`define SFDC_ADDR_BP2_SEL   8'hac
`define SFDC_ADDR_HV_OVTH   8'hb0
`define SFDC_ADDR_HV_OVHY   8'hb1
`define SFDC_ADDR_HV_UVTH   8'hb2
`define SFDC_ADDR_HV_UVHY   8'hb3
`define SFDC_ADDR_HV_SEL    8'hb4

// ----------------------------------------------------------------
// reset values and writable-bit masks
// ----------------------------------------------------------------
`define SFDC_RST_SEL        8'h00
`define SFDC_RST_OVTH       8'hff
`define SFDC_RST_UVTH       8'h00
`define SFDC_RST_HY         8'h00
`define SFDC_MASK_BP_SEL    8'hf7
`define SFDC_MASK_HV_SEL    8'h77
`define SFDC_MASK_HY        8'h1f

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SFDC_SIGN_BIT       7
`define SFDC_GF_MSB         6
`define SFDC_GF_LSB         4
`define SFDC_RANGE_BIT      2
`define SFDC_FT_MSB         1
`define SFDC_FT_LSB         0
`define SFDC_HY_MSB         4

// ----------------------------------------------------------------
// deglitch delays in microseconds and in clock cycles
// ----------------------------------------------------------------
`define SFDC_CLK_NS         100
`define SFDC_CNT_W          10
`define SFDC_GF_T0_US       0
`define SFDC_GF_T1_US       5
`define SFDC_GF_T2_US       10
`define SFDC_GF_T3_US       20
`define SFDC_GF_T4_US       30
`define SFDC_GF_T5_US       50
`define SFDC_GF_T6_US       75
`define SFDC_GF_T7_US       100
`define SFDC_GF_C0 ((`SFDC_GF_T0_US * 1000) / `SFDC_CLK_NS)
`define SFDC_GF_C1 ((`SFDC_GF_T1_US * 1000) / `SFDC_CLK_NS)
`define SFDC_GF_C2 ((`SFDC_GF_T2_US * 1000) / `SFDC_CLK_NS)
`define SFDC_GF_C3 ((`SFDC_GF_T3_US * 1000) / `SFDC_CLK_NS)
`define SFDC_GF_C4 ((`SFDC_GF_T4_US * 1000) / `SFDC_CLK_NS)
`define SFDC_GF_C5 ((`SFDC_GF_T5_US * 1000) / `SFDC_CLK_NS)
`define SFDC_GF_C6 ((`SFDC_GF_T6_US * 1000) / `SFDC_CLK_NS)
`define SFDC_GF_C7 ((`SFDC_GF_T7_US * 1000) / `SFDC_CLK_NS)

`endif

// >>> hdl/sfdc_pkg.sv
// types shared by the supply fault detector configuration block
package sfdc_pkg;

	// ----------------------------------------------------------------
	// fault type coding
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SFDC_FT_OVER   = 2'h0,
		SFDC_FT_UNDER  = 2'h1,
		SFDC_FT_WINDOW = 2'h2,
		SFDC_FT_BAD    = 2'h3
	} sfdc_fault_type;

endpackage

// >>> hdl/sfdc_top.sv
// supply fault detector configuration registers and detector logic
`timescale 1ns/1ns
`include "sfdc_defines.svh"
module sfdc_top import sfdc_pkg::*; (
	// clock and reset
	input  wire logic       mclk_i,
	input  wire logic       rst_i,
	// register port
	input  wire logic       wr_en_i,
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wdata_i,
	output logic      [7:0] rd_data_o,
	// digitised supply levels
	input  wire logic [7:0] bp1_level_i,
	input  wire logic [7:0] bp2_level_i,
	input  wire logic [7:0] hv_level_i,
	// bipolar trip points from neighbouring registers
	input  wire logic [7:0] bp1_over_trip_i,
	input  wire logic [4:0] bp1_over_hyst_i,
	input  wire logic [7:0] bp1_under_trip_i,
	input  wire logic [4:0] bp1_under_hyst_i,
	input  wire logic [7:0] bp2_over_trip_i,
	input  wire logic [4:0] bp2_over_hyst_i,
	input  wire logic [7:0] bp2_under_trip_i,
	input  wire logic [4:0] bp2_under_hyst_i,
	// analog front end steering and fault flags
	output logic      [1:0] sign_select_o,
	output logic      [2:0] range_select_o,
	output logic      [2:0] fault_o
);
	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	logic [7:0] bp1_sel_reg, bp1_sel_next;
	logic [7:0] bp2_sel_reg, bp2_sel_next;
	logic [7:0] hv_ovth_reg, hv_ovth_next;
	logic [7:0] hv_ovhy_reg, hv_ovhy_next;
	logic [7:0] hv_uvth_reg, hv_uvth_next;
	logic [7:0] hv_uvhy_reg, hv_uvhy_next;
	logic [7:0] hv_sel_reg,  hv_sel_next;
	logic [7:0] rd_data_reg, rd_data_next;

	// reserved bits are masked on write so they always read as zero
	always_comb begin
		bp1_sel_next = bp1_sel_reg;
		bp2_sel_next = bp2_sel_reg;
		hv_ovth_next = hv_ovth_reg;
		hv_ovhy_next = hv_ovhy_reg;
		hv_uvth_next = hv_uvth_reg;
		hv_uvhy_next = hv_uvhy_reg;
		hv_sel_next  = hv_sel_reg;
		if (wr_en_i) begin
			unique case (addr_i)
				`SFDC_ADDR_BP1_SEL: bp1_sel_next = wdata_i & `SFDC_MASK_BP_SEL;
				`SFDC_ADDR_BP2_SEL: bp2_sel_next = wdata_i & `SFDC_MASK_BP_SEL;
				`SFDC_ADDR_HV_OVTH: hv_ovth_next = wdata_i;
				`SFDC_ADDR_HV_OVHY: hv_ovhy_next = wdata_i & `SFDC_MASK_HY;
				`SFDC_ADDR_HV_UVTH: hv_uvth_next = wdata_i;
				`SFDC_ADDR_HV_UVHY: hv_uvhy_next = wdata_i & `SFDC_MASK_HY;
				`SFDC_ADDR_HV_SEL:  hv_sel_next  = wdata_i & `SFDC_MASK_HV_SEL;
				default: ;
			endcase
		end
		unique case (addr_i)
			`SFDC_ADDR_BP1_SEL: rd_data_next = bp1_sel_reg;
			`SFDC_ADDR_BP2_SEL: rd_data_next = bp2_sel_reg;
			`SFDC_ADDR_HV_OVTH: rd_data_next = hv_ovth_reg;
			`SFDC_ADDR_HV_OVHY: rd_data_next = hv_ovhy_reg;
			`SFDC_ADDR_HV_UVTH: rd_data_next = hv_uvth_reg;
			`SFDC_ADDR_HV_UVHY: rd_data_next = hv_uvhy_reg;
			`SFDC_ADDR_HV_SEL:  rd_data_next = hv_sel_reg;
			default:            rd_data_next = 8'h00;
		endcase
	end
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			bp1_sel_reg <= `SFDC_RST_SEL;
			bp2_sel_reg <= `SFDC_RST_SEL;
			hv_ovth_reg <= `SFDC_RST_OVTH;
			hv_ovhy_reg <= `SFDC_RST_HY;
			hv_uvth_reg <= `SFDC_RST_UVTH;
			hv_uvhy_reg <= `SFDC_RST_HY;
			hv_sel_reg  <= `SFDC_RST_SEL;
			rd_data_reg <= 8'h00;
		end else begin
			bp1_sel_reg <= bp1_sel_next;
			bp2_sel_reg <= bp2_sel_next;
			hv_ovth_reg <= hv_ovth_next;
			hv_ovhy_reg <= hv_ovhy_next;
			hv_uvth_reg <= hv_uvth_next;
			hv_uvhy_reg <= hv_uvhy_next;
			hv_sel_reg  <= hv_sel_next;
			rd_data_reg <= rd_data_next;
		end
	end
	assign rd_data_o = rd_data_reg;
	// ----------------------------------------------------------------
	// per-detector views: 0 and 1 bipolar, 2 high voltage
	// ----------------------------------------------------------------
	logic [7:0]            sel_w  [3];
	logic [7:0]            lvl_w  [3];
	logic [7:0]            othr_w [3];
	logic [4:0]            ohy_w  [3];
	logic [7:0]            uthr_w [3];
	logic [4:0]            uhy_w  [3];
	logic [2:0]            raw_w;
	logic [2:0]            over_reg,  over_next;
	logic [2:0]            under_reg, under_next;
	logic [2:0]            fault_reg, fault_next;
	logic [`SFDC_CNT_W-1:0] cnt_reg  [3];
	logic [`SFDC_CNT_W-1:0] cnt_next [3];
	logic [`SFDC_CNT_W-1:0] dly_w    [3];
	logic [1:0]            sign_reg,  sign_next;
	logic [2:0]            range_reg, range_next;
	assign sel_w  = '{bp1_sel_reg, bp2_sel_reg, hv_sel_reg};
	assign lvl_w  = '{bp1_level_i, bp2_level_i, hv_level_i};
	assign othr_w = '{bp1_over_trip_i, bp2_over_trip_i, hv_ovth_reg};
	assign ohy_w  = '{bp1_over_hyst_i, bp2_over_hyst_i,
		hv_ovhy_reg[`SFDC_HY_MSB:0]};
	assign uthr_w = '{bp1_under_trip_i, bp2_under_trip_i, hv_uvth_reg};
	assign uhy_w  = '{bp1_under_hyst_i, bp2_under_hyst_i,
		hv_uvhy_reg[`SFDC_HY_MSB:0]};
	// ----------------------------------------------------------------
	// front end steering: sign and range
	// ----------------------------------------------------------------
	// negative mode has a single range, so the range bit is forced low
	always_comb begin
		sign_next[0]  = bp1_sel_reg[`SFDC_SIGN_BIT];
		sign_next[1]  = bp2_sel_reg[`SFDC_SIGN_BIT];
		range_next[0] = bp1_sel_reg[`SFDC_RANGE_BIT] &
			~bp1_sel_reg[`SFDC_SIGN_BIT];
		range_next[1] = bp2_sel_reg[`SFDC_RANGE_BIT] &
			~bp2_sel_reg[`SFDC_SIGN_BIT];
		range_next[2] = hv_sel_reg[`SFDC_RANGE_BIT];
	end
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			sign_reg  <= 2'h0;
			range_reg <= 3'h0;
		end else begin
			sign_reg  <= sign_next;
			range_reg <= range_next;
		end
	end
	assign sign_select_o  = sign_reg;
	assign range_select_o = range_reg;
	// ----------------------------------------------------------------
	// comparators with hysteresis and deglitch filter
	// ----------------------------------------------------------------
	// levels are magnitudes, so negative rails compare the same way
	for (genvar i = 0; i < 3; i++) begin : g_det
		sfdc_fault_type ft_w;
		logic [8:0]     ohi_w;
		logic [8:0]     uhi_w;
		assign ft_w  = sfdc_fault_type'(sel_w[i][`SFDC_FT_MSB:`SFDC_FT_LSB]);
		assign ohi_w = {1'b0, lvl_w[i]} + {4'h0, ohy_w[i]};
		assign uhi_w = {1'b0, uthr_w[i]} + {4'h0, uhy_w[i]};
		always_comb begin
			// held until the level drops a hysteresis below the trip
			over_next[i]  = over_reg[i] ? (ohi_w >= {1'b0, othr_w[i]})
				: (lvl_w[i] > othr_w[i]);
			under_next[i] = under_reg[i] ? ({1'b0, lvl_w[i]} <= uhi_w)
				: (lvl_w[i] < uthr_w[i]);
			unique case (ft_w)
				SFDC_FT_OVER:   raw_w[i] = over_reg[i];
				SFDC_FT_UNDER:  raw_w[i] = under_reg[i];
				SFDC_FT_WINDOW: raw_w[i] = over_reg[i] | under_reg[i];
				default:        raw_w[i] = 1'b0;
			endcase
			unique case (sel_w[i][`SFDC_GF_MSB:`SFDC_GF_LSB])
				3'h0: dly_w[i] = `SFDC_CNT_W'(`SFDC_GF_C0);
				3'h1: dly_w[i] = `SFDC_CNT_W'(`SFDC_GF_C1);
				3'h2: dly_w[i] = `SFDC_CNT_W'(`SFDC_GF_C2);
				3'h3: dly_w[i] = `SFDC_CNT_W'(`SFDC_GF_C3);
				3'h4: dly_w[i] = `SFDC_CNT_W'(`SFDC_GF_C4);
				3'h5: dly_w[i] = `SFDC_CNT_W'(`SFDC_GF_C5);
				3'h6: dly_w[i] = `SFDC_CNT_W'(`SFDC_GF_C6);
				default: dly_w[i] = `SFDC_CNT_W'(`SFDC_GF_C7);
			endcase
			// any return of the raw level restarts the wait
			fault_next[i] = fault_reg[i];
			cnt_next[i]   = '0;
			if (raw_w[i] != fault_reg[i]) begin
				if (cnt_reg[i] >= dly_w[i]) begin
					fault_next[i] = raw_w[i];
				end else begin
					cnt_next[i] = cnt_reg[i] + 1'b1;
				end
			end
		end
		always_ff @(posedge mclk_i or posedge rst_i) begin
			if (rst_i) begin
				over_reg[i]  <= 1'b0;
				under_reg[i] <= 1'b0;
				fault_reg[i] <= 1'b0;
				cnt_reg[i]   <= '0;
			end else begin
				over_reg[i]  <= over_next[i];
				under_reg[i] <= under_next[i];
				fault_reg[i] <= fault_next[i];
				cnt_reg[i]   <= cnt_next[i];
			end
		end
	end
	assign fault_o = fault_reg;
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_over_trip_reset;
		@(posedge mclk_i) $fell(rst_i) |-> hv_ovth_reg == 8'hff;
	endproperty
	a_over_trip_reset: assert property (p_over_trip_reset)
		else $error("over trip code not all ones after reset");
	property p_under_trip_write;
		@(posedge mclk_i) disable iff (rst_i)
		wr_en_i && addr_i == `SFDC_ADDR_HV_UVTH |=>
			hv_uvth_reg == $past(wdata_i);
	endproperty
	a_under_trip_write: assert property (p_under_trip_write)
		else $error("under trip code not stored");
	property p_hyst_reserved;
		@(posedge mclk_i) disable iff (rst_i)
		hv_ovhy_reg[7:5] == 3'h0 && hv_uvhy_reg[7:5] == 3'h0;
	endproperty
	a_hyst_reserved: assert property (p_hyst_reserved)
		else $error("hysteresis reserved bits set");
	property p_sel_reserved;
		@(posedge mclk_i) disable iff (rst_i)
		!bp1_sel_reg[3] && !bp2_sel_reg[3] && !hv_sel_reg[3] &&
			!hv_sel_reg[7];
	endproperty
	a_sel_reserved: assert property (p_sel_reserved)
		else $error("select reserved bit set");
	property p_sign_follow;
		@(posedge mclk_i) disable iff (rst_i)
		wr_en_i && addr_i == `SFDC_ADDR_BP1_SEL ##1 1'b1 |=>
			sign_select_o[0] == $past(wdata_i[7], 2);
	endproperty
	a_sign_follow: assert property (p_sign_follow)
		else $error("sign select does not follow bit 7");
	property p_neg_range;
		@(posedge mclk_i) disable iff (rst_i)
		bp2_sel_reg[7] |=> !range_select_o[1];
	endproperty
	a_neg_range: assert property (p_neg_range)
		else $error("range used in negative mode");
	property p_forbidden_type;
		@(posedge mclk_i) disable iff (rst_i)
		hv_sel_reg[1:0] == 2'h3 |-> !raw_w[2];
	endproperty
	a_forbidden_type: assert property (p_forbidden_type)
		else $error("fault raised with forbidden type");
	property p_no_delay_pass;
		@(posedge mclk_i) disable iff (rst_i)
		hv_sel_reg[6:4] == 3'h0 && raw_w[2] != fault_reg[2] |=>
			fault_o[2] == $past(raw_w[2]);
	endproperty
	a_no_delay_pass: assert property (p_no_delay_pass)
		else $error("zero delay code did not pass at once");
	property p_short_masked;
		@(posedge mclk_i) disable iff (rst_i)
		$changed(fault_o[2]) |-> $past(cnt_reg[2]) == $past(dly_w[2]);
	endproperty
	a_short_masked: assert property (p_short_masked)
		else $error("fault changed before deglitch delay");
	property p_over_set;
		@(posedge mclk_i) disable iff (rst_i)
		!over_reg[2] && hv_level_i > hv_ovth_reg |=> over_reg[2];
	endproperty
	a_over_set: assert property (p_over_set)
		else $error("over level did not flag");
	property p_over_hold;
		@(posedge mclk_i) disable iff (rst_i)
		over_reg[2] && ({1'b0, hv_level_i} + {4'h0, hv_ovhy_reg[4:0]})
			>= {1'b0, hv_ovth_reg} |=> over_reg[2];
	endproperty
	a_over_hold: assert property (p_over_hold)
		else $error("over flag released inside hysteresis");
	property p_range_hv;
		@(posedge mclk_i) disable iff (rst_i)
		1'b1 |=> range_select_o[2] == $past(hv_sel_reg[2]);
	endproperty
	a_range_hv: assert property (p_range_hv)
		else $error("high-voltage range not steered");

endmodule

// >>> testbench/sfdc_rail_model.sv
// behavioural model of the three monitored supply rails
`timescale 1ns/1ns

module sfdc_rail_model (
	// clock
	input  wire logic       mclk_i,
	// digitised rail levels
	output logic      [7:0] bp1_level_o,
	output logic      [7:0] bp2_level_o,
	output logic      [7:0] hv_level_o
);
	// ----------------------------------------------------------------
	// rail levels
	// ----------------------------------------------------------------
	// clean steps only; no noise, so glitch widths are exact
	initial begin
		bp1_level_o = 8'h00;
		bp2_level_o = 8'h00;
		hv_level_o  = 8'h00;
	end

	// level changes land just after a rising edge
	task automatic set_rail(input int sel, input logic [7:0] v);
		@(posedge mclk_i);
		case (sel)
			0: bp1_level_o <= v;
			1: bp2_level_o <= v;
			default: hv_level_o <= v;
		endcase
	endtask
endmodule

// >>> testbench/supply_fault_detector_config_bench.sv
// self-checking bench for the supply fault detector configuration block
`timescale 1ns/1ns
`include "sfdc_defines.svh"

`define CHK(nm, exp, got) begin \
	cmp_count++; \
	if ((got) !== (exp)) begin \
		n_mismatch++; \
		$display("CHECK FAILED %s exp %h got %h", nm, exp, got); \
	end \
end

module supply_fault_detector_config_bench;
	import sfdc_pkg::*;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic       mclk_i = 1'b0;
	logic       rst_i  = 1'b1;
	logic       wr_en_i = 1'b0;
	logic [7:0] addr_i  = 8'h00;
	logic [7:0] wdata_i = 8'h00;
	logic [7:0] rd_data_o, bp1_lv, bp2_lv, hv_lv;
	logic [7:0] bp1_ot = 8'h80, bp1_ut = 8'h40;
	logic [7:0] bp2_ot = 8'h80, bp2_ut = 8'h40;
	logic [4:0] bp1_oh = 5'h00, bp1_uh = 5'h00;
	logic [4:0] bp2_oh = 5'h00, bp2_uh = 5'h00;
	logic [1:0] sign_select_o;
	logic [2:0] range_select_o, fault_o;
	int         n_mismatch = 0;
	int         cmp_count  = 0;
	int         dly[8] = '{0, 50, 100, 200, 300, 500, 750, 1000};

	always #50 mclk_i = ~mclk_i;

	sfdc_top sfdc_top_inst (
		.mclk_i(mclk_i), .rst_i(rst_i), .wr_en_i(wr_en_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .rd_data_o(rd_data_o),
		.bp1_level_i(bp1_lv), .bp2_level_i(bp2_lv), .hv_level_i(hv_lv),
		.bp1_over_trip_i(bp1_ot), .bp1_over_hyst_i(bp1_oh),
		.bp1_under_trip_i(bp1_ut), .bp1_under_hyst_i(bp1_uh),
		.bp2_over_trip_i(bp2_ot), .bp2_over_hyst_i(bp2_oh),
		.bp2_under_trip_i(bp2_ut), .bp2_under_hyst_i(bp2_uh),
		.sign_select_o(sign_select_o), .range_select_o(range_select_o),
		.fault_o(fault_o)
	);

	sfdc_rail_model sfdc_rail_model_inst (
		.mclk_i(mclk_i), .bp1_level_o(bp1_lv),
		.bp2_level_o(bp2_lv), .hv_level_o(hv_lv)
	);

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic settle(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		wr_en_i <= 1'b1;
		addr_i  <= a;
		wdata_i <= d;
		@(posedge mclk_i);
		wr_en_i <= 1'b0;
	endtask

	task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk_i);
		addr_i <= a;
		settle(2);
		`CHK("rd_data_o", exp, rd_data_o)
	endtask

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset_values();
		chk_reg(`SFDC_ADDR_BP1_SEL, 8'h00);
		chk_reg(`SFDC_ADDR_BP2_SEL, 8'h00);
		chk_reg(`SFDC_ADDR_HV_OVTH, 8'hff);
		chk_reg(`SFDC_ADDR_HV_UVTH, 8'h00);
		chk_reg(`SFDC_ADDR_HV_OVHY, 8'h00);
		chk_reg(`SFDC_ADDR_HV_UVHY, 8'h00);
		chk_reg(`SFDC_ADDR_HV_SEL, 8'h00);
	endtask

	// all ones written back to back; reserved bits must read zero
	task automatic t_masks();
		wr(`SFDC_ADDR_BP1_SEL, 8'hff);
		wr(`SFDC_ADDR_HV_OVHY, 8'hff);
		wr(`SFDC_ADDR_HV_UVTH, 8'hff);
		wr(`SFDC_ADDR_HV_UVHY, 8'hff);
		wr(`SFDC_ADDR_HV_SEL, 8'hff);
		wr(8'ha5, 8'hff);
		chk_reg(`SFDC_ADDR_BP1_SEL, 8'hf7);
		chk_reg(`SFDC_ADDR_HV_OVHY, 8'h1f);
		chk_reg(`SFDC_ADDR_HV_UVTH, 8'hff);
		chk_reg(`SFDC_ADDR_HV_UVHY, 8'h1f);
		chk_reg(`SFDC_ADDR_HV_SEL, 8'h77);
		chk_reg(8'ha5, 8'h00);
		wr(`SFDC_ADDR_HV_OVTH, 8'h55);
		chk_reg(`SFDC_ADDR_HV_OVTH, 8'h55);
	endtask

	task automatic t_steer();
		wr(`SFDC_ADDR_BP1_SEL, 8'h04);
		wr(`SFDC_ADDR_BP2_SEL, 8'h84);
		wr(`SFDC_ADDR_HV_SEL, 8'h04);
		settle(3);
		`CHK("sign_select_o", 2'h2, sign_select_o)
		`CHK("range_select_o", 3'h5, range_select_o)
		wr(`SFDC_ADDR_BP1_SEL, 8'h80);
		wr(`SFDC_ADDR_BP2_SEL, 8'h04);
		wr(`SFDC_ADDR_HV_SEL, 8'h00);
		settle(3);
		`CHK("sign_select_o", 2'h1, sign_select_o)
		`CHK("range_select_o", 3'h2, range_select_o)
	endtask

	// every delay code: long pulse passes delayed; codes 1 to 7 also mask a short pulse
	task automatic t_deglitch();
		logic seen;
		wr(`SFDC_ADDR_HV_OVTH, 8'h80);
		wr(`SFDC_ADDR_HV_OVHY, 8'h00);
		wr(`SFDC_ADDR_HV_UVTH, 8'h00);
		for (int c = 0; c < 8; c++) begin
			wr(`SFDC_ADDR_HV_SEL, 8'(c << 4));
			settle(3);
			if (c > 0) begin
				seen = 1'b0;
				sfdc_rail_model_inst.set_rail(2, 8'h90);
				repeat (dly[c] / 2) @(posedge mclk_i);
				sfdc_rail_model_inst.set_rail(2, 8'h10);
				repeat (dly[c] + 6) begin
					settle(1);
					seen = seen | fault_o[2];
				end
				`CHK("short pulse", 1'b0, seen)
			end
			sfdc_rail_model_inst.set_rail(2, 8'h90);
			if (c > 0) begin
				settle(dly[c]);
				`CHK("fault_o early", 1'b0, fault_o[2])
			end
			settle(4);
			`CHK("fault_o late", 1'b1, fault_o[2])
			sfdc_rail_model_inst.set_rail(2, 8'h10);
			settle(dly[c] + 4);
			`CHK("fault_o release", 1'b0, fault_o[2])
		end
	endtask

	task automatic hv_step(input logic [7:0] v, input logic exp);
		sfdc_rail_model_inst.set_rail(2, v);
		settle(5);
		`CHK("fault_o hv", exp, fault_o[2])
	endtask

	// window, under with hysteresis, and the forbidden code
	task automatic t_compare();
		wr(`SFDC_ADDR_HV_UVTH, 8'h40);
		wr(`SFDC_ADDR_HV_UVHY, 8'h04);
		wr(`SFDC_ADDR_HV_SEL, 8'h02);
		hv_step(8'h90, 1'b1);
		hv_step(8'h60, 1'b0);
		hv_step(8'h30, 1'b1);
		wr(`SFDC_ADDR_HV_SEL, 8'h01);
		hv_step(8'h43, 1'b1);
		hv_step(8'h50, 1'b0);
		hv_step(8'h90, 1'b0);
		wr(`SFDC_ADDR_HV_SEL, 8'h03);
		hv_step(8'h30, 1'b0);
		hv_step(8'h90, 1'b0);
	endtask

	// negative-mode over fault on the first, under on the second,
	// both held inside their hysteresis before release
	task automatic t_bipolar();
		wr(`SFDC_ADDR_BP1_SEL, 8'h80);
		wr(`SFDC_ADDR_BP2_SEL, 8'h01);
		sfdc_rail_model_inst.set_rail(0, 8'h90);
		bp1_oh <= 5'h10;
		sfdc_rail_model_inst.set_rail(1, 8'h20);
		bp2_uh <= 5'h10;
		settle(5);
		`CHK("fault_o bipolar", 2'h3, fault_o[1:0])
		sfdc_rail_model_inst.set_rail(0, 8'h78);
		sfdc_rail_model_inst.set_rail(1, 8'h48);
		settle(5);
		`CHK("fault_o bipolar hold", 2'h3, fault_o[1:0])
		sfdc_rail_model_inst.set_rail(0, 8'h60);
		sfdc_rail_model_inst.set_rail(1, 8'h60);
		settle(5);
		`CHK("fault_o bipolar", 2'h0, fault_o[1:0])
	endtask

	// a second reset in mid-run restores the power-on values
	task automatic t_rereset();
		@(posedge mclk_i);
		rst_i <= 1'b1;
		settle(2);
		@(posedge mclk_i);
		rst_i <= 1'b0;
		t_reset_values();
		`CHK("fault_o reset", 3'h0, fault_o)
		`CHK("sign_select_o reset", 2'h0, sign_select_o)
		`CHK("range_select_o reset", 3'h0, range_select_o)
	endtask

	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge mclk_i);
		rst_i <= 1'b0;
		t_reset_values();
		t_masks();
		t_steer();
		t_deglitch();
		t_compare();
		t_bipolar();
		t_rereset();
		test_done();
	end

	// deglitch sweep needs about 10300 cycles; allow ample margin
	initial begin
		repeat (30000) @(posedge mclk_i);
		n_mismatch++;
		test_done();
	end
endmodule
